// ===== hw/aspc_pkg.sv
package aspc_pkg;
    // data width and fifo depth
    localparam int WORD_W     = 24;
    localparam int FIFO_DEPTH = 8;
    // modulator divide factor per speed bit value
    localparam int MFACTOR_SPD0 = 128;
    localparam int MFACTOR_SPD1 = 256;
    // decimation ratio limits and value after reset
    localparam logic [10:0] DEC_MIN = 11'h014;
    localparam logic [10:0] DEC_MAX = 11'h7FF;
    localparam logic [10:0] DEC_RST = 11'h080;
    // filter select codes
    localparam logic [1:0] FSEL_AUTO = 2'h0;
    localparam logic [1:0] FLT_FAST  = 2'h1;
    localparam logic [1:0] FLT_SINC2 = 2'h2;
    localparam logic [1:0] FLT_SINC3 = 2'h3;
    // settling in output data periods
    localparam logic [1:0] SETTLE_FAST  = 2'h1;
    localparam logic [1:0] SETTLE_SINC2 = 2'h2;
    localparam logic [1:0] SETTLE_SINC3 = 2'h3;
    // command byte codes
    localparam logic [7:0] CMD_RDATA = 8'h01;
    localparam logic [3:0] CMD_RREG  = 4'h1;
    localparam logic [3:0] CMD_WREG  = 4'h5;
    // register indices
    localparam logic [3:0] REG_MODE_DEC1 = 4'h0;
    localparam logic [3:0] REG_DEC0      = 4'h1;
    localparam logic [3:0] REG_STATUS    = 4'h2;
    // mode register field positions
    localparam int MODE_DATA_READY_N_BIT  = 7;
    localparam int MODE_FSEL_LSB  = 5;
    localparam int MODE_SPEED_BIT = 4;
    // values after reset and frame counts
    localparam logic       SPEED_RST = 1'h0;
    localparam logic [1:0] FSEL_RST  = 2'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [1:0] DOR_LAST  = 2'h2;

    // serial pins as seen at the device
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
        logic clock_polarity_select;
    } aspc_pins_type;

    // serial output pin with its enable
    typedef struct packed {
        logic dout;
        logic dout_oe;
    } aspc_sout_type;

    // conversion status
    typedef struct packed {
        logic       mod_tick;
        logic       data_tick;
        logic [1:0] filter;
        logic       settled;
        logic       stall;
    } aspc_status_type;

    // serial port states
    typedef enum logic [1:0] {
        SP_CMD,
        SP_RDATA,
        SP_RREG,
        SP_WREG
    } aspc_sp_type;
endpackage : aspc_pkg

// ===== hw/aspc_fifo.sv
`timescale 1ns/1ps
module aspc_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // whole fifo state
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           cnt;
    } aspc_fifo_st_type;

    aspc_fifo_st_type q;
    aspc_fifo_st_type d;
    logic             push;
    logic             pop;

    // pointer advance with wrap at depth
    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : next_ptr

    // honest full and empty
    assign in_ready  = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // next state
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr        = next_ptr(q.wr);
        end
        if (pop) begin
            d.rd = next_ptr(q.rd);
        end
        // count moves only on one-sided traffic
        if (push && !pop) begin
            d.cnt = CW'(q.cnt + 1'b1);
        end else if (pop && !push) begin
            d.cnt = CW'(q.cnt - 1'b1);
        end
        if (srst) begin
            d = '0;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        q <= d;
    end
endmodule : aspc_fifo

// ===== hw/aspc_conv_ctrl.sv
// Function
// [R1] polarity pin inverts clock, format unchanged
// [R2] back-to-back bits and bytes without gaps
// [R3] master holds select low whole transaction
// [R4] din shifts in, dout shifts out
// [R5] ready goes low when word loaded
// [R6] ready returns high after word read
// [R7] ready high before output register update
// [R8] select tied low works; bit7 shows ready
// [R9] output code sign follows input sign
// [R10] filter settles in one, two, three periods
// [R11] auto mode steps fast, sinc2, sinc3
// [R12] decimation ratio limited to 20..2047
// [R13] modulator divides oscillator by 128 or 256
// [R14] one word per decimation ratio ticks
// [R15] deselected port ignores bus entirely
// [R16] in and out bits share clock pulse
// [R17] output released while deselected
`timescale 1ns/1ps
module aspc_conv_ctrl #(
    parameter int WORD_W     = aspc_pkg::WORD_W,
    parameter int FIFO_DEPTH = aspc_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    // serial pins, asynchronous to core_clk
    input  wire aspc_pkg::aspc_pins_type serial_pins,
    output aspc_pkg::aspc_sout_type      serial_out,
    output logic                         data_ready_n,
    // modulator result and channel select
    input  wire logic [WORD_W-1:0]       sample,
    input  wire logic [2:0]              chan_sel,
    // conversion status
    output aspc_pkg::aspc_status_type    conv_status
);
    // whole block state
    typedef struct packed {
        aspc_pkg::aspc_pins_type sync1;     // first sync stage
        aspc_pkg::aspc_pins_type sync2;     // second sync stage
        logic                    clk_prev;  // last active-level clock
        aspc_pkg::aspc_sp_type   sp;        // serial port state
        logic [2:0]              bit_cnt;   // bit within byte
        logic [1:0]              byte_cnt;  // byte within data read
        logic [7:0]              rx_sh;     // input shifter
        logic [7:0]              tx_sh;     // output shifter
        logic [3:0]              reg_idx;   // write target
        logic                    dout;      // output pin level
        logic                    dout_oe;   // output pin enable
        logic [10:0]             dec_ratio; // programmed ratio
        logic                    speed;     // modulator speed bit
        logic [1:0]              fsel;      // filter select
        logic                    data_ready_n_n;    // data ready, low active
        logic                    rd_active; // data read in flight
        logic                    upd_pend;  // output register load next
        logic [WORD_W-1:0]       data_output_register;       // data output register
        logic [7:0]              mod_cnt;   // modulator divider
        logic [10:0]             dec_cnt;   // decimation counter
        logic [2:0]              chan_prev; // last channel
        logic [1:0]              prd_cnt;   // periods since channel change
        logic                    word_pend; // word waiting for fifo
        logic [WORD_W-1:0]       word;      // finished conversion word
    } aspc_state_type;

    aspc_state_type    q;
    aspc_state_type    d;
    // edge and frame helpers
    logic              sel;
    logic              act;
    logic              rise_e;
    logic              fall_e;
    logic              byte_done;
    logic [7:0]        rx_byte;
    // conversion helpers
    logic              stall;
    logic [7:0]        mod_last;
    logic              mod_tick;
    logic [10:0]       dec_eff;
    logic              data_tick;
    logic [1:0]        flt_cur;
    logic              settled;
    logic              chan_change;
    // register read bytes
    logic [7:0]        mode_byte;
    logic [7:0]        stat_byte;
    // fifo ports
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;

    // ratio below the floor is raised to it
    function automatic logic [10:0] dec_clamp(input logic [10:0] v);
        return (v < aspc_pkg::DEC_MIN) ? aspc_pkg::DEC_MIN : v;
    endfunction : dec_clamp

    // periods a filter needs to settle
    function automatic logic [1:0] settle_of(input logic [1:0] f);
        case (f)
            aspc_pkg::FLT_FAST:  return aspc_pkg::SETTLE_FAST;
            aspc_pkg::FLT_SINC2: return aspc_pkg::SETTLE_SINC2;
            default:             return aspc_pkg::SETTLE_SINC3;
        endcase
    endfunction : settle_of

    // auto filter by periods since channel change
    function automatic logic [1:0] auto_filter(input logic [1:0] n);
        case (n)
            2'h0, 2'h1: return aspc_pkg::FLT_FAST;
            2'h2:       return aspc_pkg::FLT_SINC2;
            default:    return aspc_pkg::FLT_SINC3;
        endcase
    endfunction : auto_filter

    // register read multiplexer
    function automatic logic [7:0] reg_pick(input logic [3:0] idx, input logic [7:0] mode,
                                            input logic [7:0] lo, input logic [7:0] stat);
        case (idx)
            aspc_pkg::REG_MODE_DEC1: return mode;
            aspc_pkg::REG_DEC0:      return lo;
            aspc_pkg::REG_STATUS:    return stat;
            default:                 return 8'h00;
        endcase
    endfunction : reg_pick

    // serial edges, only while selected
    assign sel       = ~q.sync2.cs_n;                        // see [R15]
    assign act       = q.sync2.sclk ^ q.sync2.clock_polarity_select;           // see [R1]
    assign rise_e    = sel & act & ~q.clk_prev;
    assign fall_e    = sel & ~act & q.clk_prev;
    assign rx_byte   = {q.rx_sh[6:0], q.sync2.din};
    assign byte_done = rise_e & (q.bit_cnt == aspc_pkg::BIT_LAST);

    // modulator and decimation timing
    assign stall       = q.word_pend & ~fifo_in_ready;
    assign mod_last    = q.speed ? 8'(aspc_pkg::MFACTOR_SPD1 - 1)
                                 : 8'(aspc_pkg::MFACTOR_SPD0 - 1);  // see [R13]
    assign mod_tick    = ~stall & (q.mod_cnt == mod_last);
    assign dec_eff     = dec_clamp(q.dec_ratio);                    // see [R12]
    assign data_tick   = mod_tick & (q.dec_cnt >= 11'(dec_eff - 11'h001));  // see [R14]
    assign chan_change = (chan_sel != q.chan_prev);

    // active filter and settling state
    assign flt_cur = (q.fsel == aspc_pkg::FSEL_AUTO) ? auto_filter(q.prd_cnt) : q.fsel;  // see [R11]
    assign settled = (q.prd_cnt >= settle_of(flt_cur));                                  // see [R10]

    // readable register bytes, ready state in bit 7 of the mode byte, settled in bit 7 of the status byte
    assign mode_byte = {q.data_ready_n_n, q.fsel, q.speed, 1'b0, q.dec_ratio[10:8]};  // see [R8]
    assign stat_byte = {settled, flt_cur, q.word_pend, 4'h0};

    // drain one word per output register load
    assign fifo_out_ready = q.upd_pend;

    // word buffer between decimator and output register
    aspc_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_valid  (q.word_pend),
        .in_ready  (fifo_in_ready),
        .in_data   (q.word),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // next state of the whole block
    always_comb begin
        d          = q;
        // two-stage pin synchroniser
        d.sync1    = serial_pins;
        d.sync2    = q.sync1;
        d.clk_prev = act;

        // modulator divider freezes while a word waits on a full fifo
        if (!stall) begin
            d.mod_cnt = mod_tick ? 8'h00 : 8'(q.mod_cnt + 8'h01);
        end
        if (mod_tick) begin
            d.dec_cnt = data_tick ? 11'h000 : 11'(q.dec_cnt + 11'h001);
        end
        // word handed to fifo
        if (q.word_pend && fifo_in_ready) begin
            d.word_pend = 1'b0;
        end
        // end of output data period
        if (data_tick) begin
            d.word      = sample;          // see [R9]
            d.word_pend = 1'b1;
            if (q.prd_cnt != 2'h3) begin
                d.prd_cnt = 2'(q.prd_cnt + 2'h1);
            end
        end
        // new channel restarts settling
        d.chan_prev = chan_sel;
        if (chan_change) begin
            d.prd_cnt = 2'h0;              // see [R11]
        end

        // output register load, ready already high
        if (!q.upd_pend && q.data_ready_n_n && !q.rd_active && fifo_out_valid) begin
            d.upd_pend = 1'b1;             // see [R7]
        end
        if (q.upd_pend) begin
            d.upd_pend = 1'b0;
            d.data_output_register      = fifo_out_data;
            d.data_ready_n_n   = 1'b0;             // see [R5]
        end

        // serial port
        if (!sel) begin
            // deselected: frame reset, output released
            d.sp        = aspc_pkg::SP_CMD;
            d.bit_cnt   = 3'h0;
            d.byte_cnt  = 2'h0;
            d.dout_oe   = 1'b0;            // see [R17]
            d.rd_active = 1'b0;
        end else begin
            d.dout_oe = 1'b1;
            // sample din on the active edge
            if (rise_e) begin
                d.rx_sh   = rx_byte;       // see [R4]
                d.bit_cnt = 3'(q.bit_cnt + 3'h1);
            end
            // present next bit on the trailing edge of the same pulse
            if (fall_e) begin
                d.dout  = q.tx_sh[7];      // see [R16]
                d.tx_sh = {q.tx_sh[6:0], 1'b0};
            end
            // whole byte received
            if (byte_done) begin
                d.tx_sh = 8'h00;
                case (q.sp)
                    aspc_pkg::SP_CMD: begin
                        if (rx_byte == aspc_pkg::CMD_RDATA) begin
                            d.sp        = aspc_pkg::SP_RDATA;
                            d.byte_cnt  = 2'h0;
                            d.rd_active = 1'b1;
                            // a load in this cycle is seen at once
                            d.tx_sh     = q.upd_pend ? fifo_out_data[WORD_W-1 -: 8]
                                                     : q.data_output_register[WORD_W-1 -: 8];
                        end else if (rx_byte[7:4] == aspc_pkg::CMD_RREG) begin
                            d.sp    = aspc_pkg::SP_RREG;
                            d.tx_sh = reg_pick(rx_byte[3:0], mode_byte,
                                               q.dec_ratio[7:0], stat_byte);
                        end else if (rx_byte[7:4] == aspc_pkg::CMD_WREG) begin
                            d.sp      = aspc_pkg::SP_WREG;
                            d.reg_idx = rx_byte[3:0];
                        end
                    end
                    aspc_pkg::SP_RDATA: begin
                        // bytes follow back to back
                        d.byte_cnt = 2'(q.byte_cnt + 2'h1);   // see [R2]
                        case (q.byte_cnt)
                            2'h0:    d.tx_sh = q.data_output_register[WORD_W-9 -: 8];
                            2'h1:    d.tx_sh = q.data_output_register[WORD_W-17 -: 8];
                            default: d.tx_sh = 8'h00;
                        endcase
                        if (q.byte_cnt == aspc_pkg::DOR_LAST) begin
                            d.sp        = aspc_pkg::SP_CMD;
                            d.rd_active = 1'b0;
                            d.data_ready_n_n    = 1'b1;           // see [R6]
                        end
                    end
                    aspc_pkg::SP_WREG: begin
                        // ready bit and bit 3 are read-only
                        case (q.reg_idx)
                            aspc_pkg::REG_MODE_DEC1: begin
                                d.fsel             = rx_byte[aspc_pkg::MODE_FSEL_LSB +: 2];
                                d.speed            = rx_byte[aspc_pkg::MODE_SPEED_BIT];
                                d.dec_ratio[10:8]  = rx_byte[2:0];
                            end
                            aspc_pkg::REG_DEC0: d.dec_ratio[7:0] = rx_byte;
                            default: ;
                        endcase
                        d.sp = aspc_pkg::SP_CMD;
                    end
                    default: d.sp = aspc_pkg::SP_CMD;
                endcase
            end
        end

        // synchronous reset
        if (srst) begin
            d             = '0;
            d.sync1.cs_n  = 1'b1;
            d.sync2.cs_n  = 1'b1;
            d.sp          = aspc_pkg::SP_CMD;
            d.data_ready_n_n      = 1'b1;
            d.dec_ratio   = aspc_pkg::DEC_RST;
            d.speed       = aspc_pkg::SPEED_RST;
            d.fsel        = aspc_pkg::FSEL_RST;
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        q <= d;
    end

    // outputs
    assign serial_out.dout        = q.dout;
    assign serial_out.dout_oe     = q.dout_oe;
    assign data_ready_n           = q.data_ready_n_n;
    assign conv_status.mod_tick   = mod_tick;
    assign conv_status.data_tick  = data_tick;
    assign conv_status.filter     = flt_cur;
    assign conv_status.settled    = settled;
    assign conv_status.stall      = stall;

    // deselect releases the output line
    cs_release_a: assert property (@(posedge core_clk) disable iff (srst) // see [R17]
        q.sync2.cs_n |=> !q.dout_oe)
        else $error("dout driven while deselected");

    // din bit captured on the active edge
    rx_sample_a: assert property (@(posedge core_clk) disable iff (srst) // see [R4]
        rise_e |=> q.rx_sh[0] == $past(q.sync2.din))
        else $error("din not sampled on active edge");

    // load drives ready low
    data_ready_n_low_a: assert property (@(posedge core_clk) disable iff (srst) // see [R5]
        (q.upd_pend && !srst) |=> !q.data_ready_n_n && q.data_output_register == $past(fifo_out_data))
        else $error("ready not low after load");

    // third data byte frees ready
    data_ready_n_high_a: assert property (@(posedge core_clk) disable iff (srst) // see [R6]
        (byte_done && q.sp == aspc_pkg::SP_RDATA && q.byte_cnt == 2'h2) |=> q.data_ready_n_n)
        else $error("ready not high after read");

    // output register changes only behind a raised ready
    dor_guard_a: assert property (@(posedge core_clk) disable iff (srst) // see [R7]
        !$stable(q.data_output_register) |-> $past(q.data_ready_n_n, 2) && $past(q.upd_pend))
        else $error("register updated without ready high");

    // bit 7 of mode register mirrors ready
    mode_bit7_a: assert property (@(posedge core_clk) disable iff (srst) // see [R8]
        (byte_done && q.sp == aspc_pkg::SP_CMD && rx_byte == 8'h10)
        |=> q.tx_sh[7] == $past(q.data_ready_n_n))
        else $error("mode bit 7 differs from ready");

    // effective ratio stays in range
    dec_range_a: assert property (@(posedge core_clk) disable iff (srst) // see [R12]
        dec_eff >= aspc_pkg::DEC_MIN && (q.dec_ratio < aspc_pkg::DEC_MIN || dec_eff == q.dec_ratio))
        else $error("decimation ratio out of range");

    // modulator tick at the divide factor
    mod_div_a: assert property (@(posedge core_clk) disable iff (srst) // see [R13]
        mod_tick |-> q.mod_cnt == (q.speed ? 8'hFF : 8'h7F))
        else $error("modulator divide wrong");

    // one word per period, sign kept
    word_rate_a: assert property (@(posedge core_clk) disable iff (srst) // see [R14]
        data_tick |=> q.word_pend && q.dec_cnt == 11'h000 && q.word == $past(sample))
        else $error("output word not produced");

    // auto mode restarts with the fast filter
    auto_fast_a: assert property (@(posedge core_clk) disable iff (srst) // see [R11]
        (chan_change && q.fsel == aspc_pkg::FSEL_AUTO && !data_tick)
        |=> flt_cur == aspc_pkg::FLT_FAST && !settled)
        else $error("auto filter did not restart");

    // third-order filter not settled before three periods
    sinc3_settle_a: assert property (@(posedge core_clk) disable iff (srst) // see [R10]
        (flt_cur == aspc_pkg::FLT_SINC3) |-> settled == (q.prd_cnt == 2'h3))
        else $error("sinc3 settled early");
endmodule : aspc_conv_ctrl

// ===== verif/aspc_host_model.sv
`timescale 1ns/1ps
module aspc_host_model (
    // clock
    input  wire logic                    core_clk,
    // pins toward the port
    output aspc_pkg::aspc_pins_type      pins,
    input  wire aspc_pkg::aspc_sout_type sout
);
    logic keep_sel = 1'b0;  // select held low between frames
    logic busy     = 1'b0;  // frame set-up or transfer under way
    int   ph       = 4;     // core_clk cycles per clock phase
    initial pins = '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0, clock_polarity_select: 1'b0};
    // released data line toggles every cycle
    always @(negedge core_clk) begin
        if (pins.cs_n && !busy) begin
            pins.din <= ~pins.din;
        end
    end
    // frame of nbits from w, msb first; returned bits gathered in r
    task automatic xfer(input logic [31:0] w, input int nbits, input logic p, output logic [31:0] r);
        r = 32'h0;
        busy = 1'b1;
        @(negedge core_clk);
        if (pins.cs_n) begin
            pins.clock_polarity_select  = p;
            pins.sclk = p;
            repeat (ph) @(negedge core_clk);
            pins.cs_n = 1'b0;
        end
        for (int i = 0; i < nbits; i++) begin
            pins.din = w[31 - i];
            repeat (ph) @(negedge core_clk);
            pins.sclk = ~pins.clock_polarity_select;
            // a released line reads back inverted
            r = {r[30:0], sout.dout_oe ? sout.dout : ~sout.dout};
            repeat (ph) @(negedge core_clk);
            pins.sclk = pins.clock_polarity_select;
        end
        repeat (ph) @(negedge core_clk);
        if (!keep_sel) begin
            pins.cs_n = 1'b1;
        end
        repeat (ph) @(negedge core_clk);
        busy = 1'b0;
    endtask : xfer
endmodule : aspc_host_model

// ===== verif/test_adc_serial_port_conv_ctrl.sv
`timescale 1ns/1ps
module test_adc_serial_port_conv_ctrl;
    logic                      core_clk = 1'b0;
    logic                      srst     = 1'b1;
    logic [23:0]               sample   = 24'h5A5A5A;
    logic [2:0]                chan_sel = 3'h0;
    aspc_pkg::aspc_pins_type   pins;
    aspc_pkg::aspc_sout_type   sout;
    aspc_pkg::aspc_status_type st;
    logic                      data_ready_n_n;
    logic                      data_ready_n_q   = 1'b1;
    logic [31:0]               seed     = 32'hD647DED4;
    logic [31:0]               rd;
    logic [23:0]               exp_q[$];  // words expected in order
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rises = 0;
    int hi_cnt = 0;
    int n;

    aspc_conv_ctrl #(.WORD_W(24), .FIFO_DEPTH(8)) i_dut (.core_clk(core_clk), .srst(srst),
        .serial_pins(pins), .serial_out(sout), .data_ready_n(data_ready_n_n), .sample(sample),
        .chan_sel(chan_sel), .conv_status(st));
    aspc_host_model i_host (.core_clk(core_clk), .pins(pins), .sout(sout));

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    function automatic logic [31:0] nxt(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : nxt

    // filter expected in a mode after n periods
    function automatic logic [1:0] exp_f(input int fs, input int n);
        if (fs != 0) return fs[1:0];
        return (n < 2) ? 2'h1 : (n == 2) ? 2'h2 : 2'h3;
    endfunction : exp_f

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("failures=%0d cmp_count=%0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // monitors: ticks, ready edges, released output, watchdog
    always @(negedge core_clk) begin
        cyc <= cyc + 1;
        data_ready_n_q <= data_ready_n_n;
        hi_cnt <= pins.cs_n ? hi_cnt + 1 : 0;
        if (data_ready_n_n === 1'b1 && data_ready_n_q === 1'b0) rises <= rises + 1;
        if (st.data_tick === 1'b1) exp_q.push_back(sample);
        if (st.mod_tick === 1'b1 && st.data_tick !== 1'b1) begin
            seed <= nxt(seed);
            sample <= seed[23:0];
        end
        if (hi_cnt > 4) chk(sout.dout_oe, 1'b0);
        if (cyc == 95000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic rreg(input logic [3:0] idx, input logic [7:0] e);
        i_host.xfer({aspc_pkg::CMD_RREG, idx, 24'h0}, 16, seed[31], rd);
        chk(rd[7:0], e);
    endtask : rreg

    task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
        i_host.xfer({aspc_pkg::CMD_WREG, idx, d, 16'h0}, 16, seed[30], rd);
    endtask : wreg

    // interval to the next mod (d=0) or data (d=1) tick
    task automatic tick(input bit d, output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while ((d ? st.data_tick : st.mod_tick) !== 1'b1);
    endtask : tick

    // read every pending word at random pace and polarity
    task automatic drain();
        int r0;
        logic [23:0] e;
        while (exp_q.size() > 0) begin
            while (data_ready_n_n !== 1'b0) @(negedge core_clk);
            r0 = rises;
            e = exp_q.pop_front();
            i_host.ph = 4 + seed[29:28];
            i_host.xfer({aspc_pkg::CMD_RDATA, 24'h0}, 32, seed[31], rd);
            i_host.ph = 4;
            chk(rd[23:0], e);
            repeat (8) @(negedge core_clk);
            chk(rises, r0 + 1);
        end
    endtask : drain

    initial begin
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        chk(data_ready_n_n, 1'b1);
        i_host.keep_sel = 1'b1;
        rreg(aspc_pkg::REG_MODE_DEC1, 8'h80);
        rreg(aspc_pkg::REG_DEC0, 8'h80);
        wreg(aspc_pkg::REG_DEC0, 8'h14);
        wreg(aspc_pkg::REG_MODE_DEC1, 8'h18);
        i_host.keep_sel = 1'b0;
        i_host.xfer(32'h50000000, 4, 1'b0, rd);
        rreg(aspc_pkg::REG_MODE_DEC1, 8'h90);
        rreg(aspc_pkg::REG_DEC0, 8'h14);
        repeat (3) tick(1'b0, n);
        chk(n, 256);
        wreg(aspc_pkg::REG_MODE_DEC1, 8'h00);
        repeat (3) tick(1'b0, n);
        chk(n, 128);
        repeat (3) tick(1'b1, n);
        chk(n, 2560);
        for (int fs = 0; fs < 4; fs++) begin
            drain();
            wreg(aspc_pkg::REG_MODE_DEC1, {1'b0, fs[1:0], 5'h00});
            chan_sel = chan_sel + 3'h1;
            for (int k = 0; k < 4; k++) begin
                repeat (2) @(negedge core_clk);
                chk(st.filter, exp_f(fs, k));
                chk(st.settled, k >= int'(exp_f(fs, k)));
                if (k < 3) tick(1'b1, n);
            end
        end
        while (st.stall !== 1'b1) @(negedge core_clk);
        chk(exp_q.size(), 10);
        i_host.keep_sel = 1'b1;
        rreg(aspc_pkg::REG_MODE_DEC1, 8'h60);
        i_host.keep_sel = 1'b0;
        drain();
        chk(st.stall, 1'b0);
        wrap_up();
    end
endmodule : test_adc_serial_port_conv_ctrl
